// file: core/ocg_pkg.sv
// Shared constants, types and helpers for the display addressing block
// Overview of operation
// - Host memory writes and refresh reads use separate ports, so refresh is undisturbed.
// - Sixteen row drive outputs and one hundred column drive outputs.
// - Rows in use get the selection pulse; all other rows stay non-selected.
// - Cursor or blink appears at the cell whose address the cursor counter holds.
// - One-line mode: positions 1 to 20 map to addresses 00 to 13 hex.
// - Two-line mode: line one is 00 to 13 hex, line two 40 to 53 hex.
// - Counter in pattern memory may place the cursor anywhere meaningless.
// - One-line character mode offers 128 positions, codes 10000000 upward.
// - Two-line mode: 64 positions per line, line two starts at 11000000.
// - Address command with top bit set loads the seven-bit position.
// - Graphic mode shows a 100 by 16 bitmap directly from memory.
// - Graphic column set by display address, row group by pattern address.
// - Row group code is 0100000 plus a select bit for upper or lower group.
// - Graphic column codes run 10000000 for column 1 to 11100011 for 100.
// - Two-bit font select picks the built-in font; 00 after reset.
// - Font select 01, 10, 11 pick the other three built-in fonts.
// - Codes with upper four bits zero use user patterns instead of fonts.
package ocg_pkg;
  // Register offsets
  localparam logic [3:0] REG_CMD   = 4'h0;
  localparam logic [3:0] REG_DATA  = 4'h1;
  localparam logic [3:0] REG_CONF  = 4'h2;
  localparam logic [3:0] REG_STAT  = 4'h3;
  localparam logic [3:0] REG_GROUP = 4'h4;
  // Configuration field positions and reset value
  localparam int         CONF_TWO_LINE = 0;
  localparam int         CONF_GRAPHIC  = 1;
  localparam int         CONF_FONT     = 2;
  localparam int         CONF_CURSOR   = 4;
  localparam int         CONF_BLINK    = 5;
  localparam int         CONF_INC      = 6;
  localparam logic [7:0] CONF_RST      = 8'h40;
  // Command encodings
  localparam logic [6:0] GY_PREFIX     = 7'h20;
  // Panel geometry
  localparam logic [6:0] COL_LAST      = 7'h63;
  localparam logic [2:0] CELL_LAST     = 3'h4;
  localparam logic [3:0] ROW_LAST      = 4'hf;
  localparam logic [2:0] CURSOR_ROW    = 3'h7;
  localparam logic [6:0] LINE2_BASE    = 7'h40;
  // Timing
  localparam int         CLK_MHZ       = 25;
  localparam int         PIX_TIME_NS   = 200;
  localparam int         PIX_CYCLES    = (PIX_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int         BLINK_FRAMES  = 32;

  typedef enum logic [1:0] {
    OCG_FONT_EN_JP = 2'b00,
    OCG_FONT_WE    = 2'b01,
    OCG_FONT_EN_RU = 2'b10,
    OCG_FONT_WE2   = 2'b11
  } ocg_font_t;

  // Display memory address of a character cell
  function automatic logic [6:0] ocg_char_addr(input logic two_line, input logic line, input logic [4:0] pos);
    ocg_char_addr = (two_line && line) ? LINE2_BASE + {2'b00, pos} : {2'b00, pos};
  endfunction
endpackage

// file: core/ocg_scan_if.sv
// Refresh scan position shared between scanner and pixel logic
`timescale 1ns/1ps
`default_nettype none
interface ocg_scan_if;
  logic       pix_en;
  logic [6:0] col;
  logic [4:0] pos;
  logic [2:0] sub;
  logic [3:0] row;
  logic       row_end;
  logic       frame_end;
  modport src (output pix_en, col, pos, sub, row, row_end, frame_end);
  modport dst (input pix_en, col, pos, sub, row, row_end, frame_end);
endinterface
`default_nettype wire

// file: core/ocg_scan.sv
// Refresh scanner: pixel enable, column, cell and row counters
`timescale 1ns/1ps
`default_nettype none
module ocg_scan
  import ocg_pkg::*;
#(
  parameter int PIX_DIV = PIX_CYCLES
)(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Scan position
  ocg_scan_if.src  scan
);
  logic [7:0] div;
  logic       last_col;

  // Pixel rate divider
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      div <= 8'h00;
    else if (div == 8'(PIX_DIV - 1))
      div <= 8'h00;
    else
      div <= div + 8'h01;
  end

  assign scan.pix_en    = (div == 8'(PIX_DIV - 1));
  assign last_col       = (scan.col == COL_LAST);
  assign scan.row_end   = scan.pix_en && last_col;
  assign scan.frame_end = scan.row_end && (scan.row == ROW_LAST);

  // Column and cell counters
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      scan.col <= 7'h00;
      scan.pos <= 5'h00;
      scan.sub <= 3'h0;
    end
    else if (scan.pix_en)
    begin
      if (last_col)
      begin
        scan.col <= 7'h00;
        scan.pos <= 5'h00;
        scan.sub <= 3'h0;
      end
      else
      begin
        scan.col <= scan.col + 7'h01;
        scan.sub <= (scan.sub == CELL_LAST) ? 3'h0 : scan.sub + 3'h1;
        scan.pos <= (scan.sub == CELL_LAST) ? scan.pos + 5'h01 : scan.pos;
      end
    end
  end

  // Row counter, wraps after sixteen rows
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      scan.row <= 4'h0;
    else if (scan.row_end)
      scan.row <= scan.row + 4'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  col_in_range_a: assert property (scan.col <= COL_LAST && scan.sub <= CELL_LAST)
    else $error("scan column out of range");
endmodule
`default_nettype wire

// file: core/ocg_font.sv
// Built-in font lookup, four selectable sets of synthetic glyph rows
`timescale 1ns/1ps
`default_nettype none
module ocg_font
  import ocg_pkg::*;
(
  // Lookup request
  input  wire logic [1:0] font_select,
  input  wire logic [7:0] code,
  input  wire logic [2:0] crow,
  // Glyph row, bit 4 leftmost
  output logic      [4:0] glyph
);
  // Glyph art is a stand-in; each set gives a distinct row pattern
  always_comb
  begin
    unique case (ocg_font_t'(font_select))
      OCG_FONT_EN_JP: glyph = code[4:0] ^ {crow, 2'b00};
      OCG_FONT_WE:    glyph = code[7:3] ^ {2'b00, crow};
      OCG_FONT_EN_RU: glyph = ~(code[4:0] ^ {crow, 2'b01});
      OCG_FONT_WE2:   glyph = {code[0], code[7:4]} ^ {crow, crow[1:0]};
    endcase
  end
endmodule
`default_nettype wire

// file: core/ocg_addressing.sv
// Character and graphic addressing, cursor and refresh drive of the display controller
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ocg_addressing
  import ocg_pkg::*;
#(
  parameter int PIX_DIV = PIX_CYCLES,
  parameter int BLINK   = BLINK_FRAMES
)(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Register port
  input  wire logic [3:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  // Panel drive
  output logic      [15:0]  row_drive,
  output logic      [99:0]  col_drive
);
  ocg_scan_if scan ();

  logic [7:0]  disp_mem [0:255];
  logic [4:0]  pat_mem  [0:63];
  logic [7:0]  conf;
  logic [6:0]  cursor_address_counter;
  logic [6:0]  next_ac;
  logic        in_pattern;
  logic        row_group_select_bit;
  logic        cmd_wr;
  logic        data_wr;
  logic        two_line;
  logic        graphic;
  logic        inc;
  logic        line;
  logic [2:0]  crow;
  logic [6:0]  char_addr;
  logic [7:0]  char_code;
  logic [7:0]  gfx_byte;
  logic [4:0]  font_row;
  logic [4:0]  glyph_row;
  logic        user_glyph;
  logic        cur_hit;
  logic        char_pix;
  logic        pixel;
  logic        row_used;
  logic [99:0] seg_line;
  logic        fire;
  logic [3:0]  done_row;
  logic        done_used;
  logic [4:0]  frame_cnt;
  logic        blink_phase;
  logic        group_cmd;
  logic [15:0] hold_cnt;
  logic        hold_armed;

  assign cmd_wr   = reg_wr && (reg_addr == REG_CMD);
  assign data_wr  = reg_wr && (reg_addr == REG_DATA);
  assign two_line = conf[CONF_TWO_LINE];
  assign graphic  = conf[CONF_GRAPHIC];
  assign inc      = conf[CONF_INC];

  // Row group command, recognised in graphic mode only
  assign group_cmd = cmd_wr && graphic && (reg_wdata[7:1] == GY_PREFIX);

  // Configuration register: line count, mode, font, cursor, blink, direction
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      conf <= CONF_RST;
    else if (reg_wr && (reg_addr == REG_CONF))
      conf <= reg_wdata;
  end

  // Counter step after a data write
  always_comb
  begin
    next_ac = cursor_address_counter;
    if (graphic)
      next_ac = inc ? ((cursor_address_counter >= COL_LAST) ? 7'h00 : cursor_address_counter + 7'h01)
                    : ((cursor_address_counter == 7'h00) ? COL_LAST : cursor_address_counter - 7'h01);
    else if (in_pattern)
      next_ac = {1'b0, inc ? cursor_address_counter[5:0] + 6'h01 : cursor_address_counter[5:0] - 6'h01};
    else
      next_ac = inc ? cursor_address_counter + 7'h01 : cursor_address_counter - 7'h01;
  end

  // Cursor counter and target memory select
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cursor_address_counter <= 7'h00;
      in_pattern             <= 1'b0;
    end
    else if (cmd_wr && reg_wdata[7])
    begin
      cursor_address_counter <= reg_wdata[6:0];
      in_pattern             <= 1'b0;
    end
    else if (cmd_wr && (reg_wdata[7:6] == 2'b01) && !graphic)
    begin
      cursor_address_counter <= {1'b0, reg_wdata[5:0]};
      in_pattern             <= 1'b1;
    end
    else if (group_cmd)
      in_pattern             <= 1'b0;
    else if (data_wr)
      cursor_address_counter <= next_ac;
  end

  // Graphic row group select
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      row_group_select_bit <= 1'b0;
    else if (group_cmd)
      row_group_select_bit <= reg_wdata[0];
  end

  // Host write port, separate from the refresh read port
  always_ff @(posedge sys_clk)
  begin
    if (data_wr && graphic)
      disp_mem[{row_group_select_bit, cursor_address_counter}] <= reg_wdata;
    else if (data_wr && !in_pattern)
      disp_mem[{1'b0, cursor_address_counter}] <= reg_wdata;
  end

  // User pattern memory write
  always_ff @(posedge sys_clk)
  begin
    if (data_wr && !graphic && in_pattern)
      pat_mem[cursor_address_counter[5:0]] <= reg_wdata[4:0];
  end

  // Register read, data valid the cycle after the strobe only
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_CONF:  reg_rdata <= conf;
        REG_STAT:  reg_rdata <= {in_pattern, cursor_address_counter};
        REG_GROUP: reg_rdata <= {7'h00, row_group_select_bit};
        default:   reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  ocg_scan #(
    .PIX_DIV (PIX_DIV)
  ) u_scan (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .scan    (scan)
  );

  // Refresh read side: cell and pixel selection
  assign line       = scan.row[3];
  assign crow       = scan.row[2:0];
  assign char_addr  = ocg_char_addr(two_line, line, scan.pos);
  assign char_code  = disp_mem[{1'b0, char_addr}];
  assign gfx_byte   = disp_mem[{line, scan.col}];
  assign user_glyph = (char_code[7:4] == 4'h0);
  assign glyph_row  = user_glyph ? pat_mem[{char_code[2:0], crow}] : font_row;
  assign cur_hit    = (char_addr == cursor_address_counter);
  assign row_used   = graphic || two_line || !line;

  ocg_font u_font (
    .font_select (conf[CONF_FONT +: 2]),
    .code        (char_code),
    .crow        (crow),
    .glyph       (font_row)
  );

  // Character pixel with cursor underline and blink fill
  always_comb
  begin
    char_pix = glyph_row[CELL_LAST - scan.sub];
    if (cur_hit && conf[CONF_CURSOR] && (crow == CURSOR_ROW))
      char_pix = 1'b1;
    if (cur_hit && conf[CONF_BLINK] && blink_phase)
      char_pix = 1'b1;
  end

  assign pixel = row_used && (graphic ? gfx_byte[crow] : char_pix);

  // Collect one row of column pixels
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      seg_line <= '0;
    else if (scan.pix_en)
      seg_line[scan.col] <= pixel;
  end

  // Row finished: remember which one and whether it is in use
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      fire      <= 1'b0;
      done_row  <= 4'h0;
      done_used <= 1'b0;
    end
    else
    begin
      fire      <= scan.row_end;
      done_row  <= scan.row_end ? scan.row : done_row;
      done_used <= scan.row_end ? row_used : done_used;
    end
  end

  // Drive latch: selection on the finished row if in use, non-selection elsewhere
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      row_drive <= 16'h0000;
      col_drive <= '0;
    end
    else if (fire)
    begin
      row_drive <= done_used ? (16'h0001 << done_row) : 16'h0000;
      col_drive <= seg_line;
    end
  end

  // Blink phase toggles every BLINK frames
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      frame_cnt   <= 5'h00;
      blink_phase <= 1'b0;
    end
    else if (scan.frame_end)
    begin
      frame_cnt   <= (frame_cnt == 5'(BLINK - 1)) ? 5'h00 : frame_cnt + 5'h01;
      blink_phase <= (frame_cnt == 5'(BLINK - 1)) ? !blink_phase : blink_phase;
    end
  end

  // Cycles since the last drive latch, for the row spacing check
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      hold_cnt   <= 16'h0000;
      hold_armed <= 1'b0;
    end
    else if (fire)
    begin
      hold_cnt   <= 16'h0000;
      hold_armed <= 1'b1;
    end
    else if (hold_cnt != 16'hffff)
      hold_cnt <= hold_cnt + 16'h0001;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  addr_load_a: assert property (cmd_wr && reg_wdata[7] |=> cursor_address_counter == $past(reg_wdata[6:0]))
    else $error("address command not loaded");
  char_step_a: assert property (data_wr && !graphic && !in_pattern && inc
                                |=> cursor_address_counter == $past(cursor_address_counter) + 7'h01)
    else $error("counter did not advance after write");
  gfx_wrap_a: assert property (data_wr && graphic && inc && cursor_address_counter == COL_LAST
                               |=> cursor_address_counter == 7'h00)
    else $error("graphic column did not wrap after 100");
  row_group_a: assert property (cmd_wr && graphic && reg_wdata[7:1] == GY_PREFIX
                                |=> row_group_select_bit == $past(reg_wdata[0]) && !in_pattern)
    else $error("row group select not taken");
  row_select_a: assert property (fire |=> row_drive == ($past(done_used) ? 16'h0001 << $past(done_row) : 16'h0000))
    else $error("row drive does not match finished row");
  one_row_a: assert property ($onehot0(row_drive))
    else $error("more than one row selected");
  line_map_a: assert property (!graphic && scan.pos <= 5'h13
                               |-> char_addr == ((two_line && line) ? 7'h40 : 7'h00) + {2'b00, scan.pos})
    else $error("cell address mapping wrong");
  stat_read_a: assert property (reg_rd && reg_addr == REG_STAT
                                |=> reg_rdata == {$past(in_pattern), $past(cursor_address_counter)})
    else $error("status read mismatch");
  font_reset_a: assert property ($rose(rst_n) |-> conf[CONF_FONT +: 2] == 2'b00 && reg_rdata == 8'h00)
    else $error("font select not default after reset");
  user_glyph_a: assert property (!graphic && char_code[7:4] == 4'h0
                                 |-> glyph_row == pat_mem[{char_code[2:0], crow}])
    else $error("user pattern not selected");

  // Counter and register checks
  pat_load_a: assert property (cmd_wr && reg_wdata[7:6] == 2'b01 && !graphic
                               |=> in_pattern && cursor_address_counter == {1'b0, $past(reg_wdata[5:0])})
    else $error("pattern address not loaded");
  pat_step_a: assert property (data_wr && !graphic && in_pattern && inc
                               |=> cursor_address_counter == {1'b0, $past(cursor_address_counter[5:0]) + 6'h01})
    else $error("pattern address did not advance");
  char_down_a: assert property (data_wr && !graphic && !in_pattern && !inc
                                |=> cursor_address_counter == $past(cursor_address_counter) - 7'h01)
    else $error("counter did not step down after write");
  char_wrap_a: assert property (data_wr && !graphic && !in_pattern && inc && cursor_address_counter == 7'h7f
                                |=> cursor_address_counter == 7'h00)
    else $error("character counter did not wrap after 128");
  gfx_step_a: assert property (data_wr && graphic && inc && cursor_address_counter < COL_LAST
                               |=> cursor_address_counter == $past(cursor_address_counter) + 7'h01)
    else $error("graphic column did not advance");
  gfx_down_a: assert property (data_wr && graphic && !inc && cursor_address_counter != 7'h00
                               && cursor_address_counter <= COL_LAST
                               |=> cursor_address_counter == $past(cursor_address_counter) - 7'h01)
    else $error("graphic column did not step down");
  group_keep_a: assert property (cmd_wr && graphic && reg_wdata[7:6] == 2'b01 && !group_cmd
                                 |=> row_group_select_bit == $past(row_group_select_bit))
    else $error("row group changed by foreign command");
  conf_read_a: assert property (reg_rd && reg_addr == REG_CONF |=> reg_rdata == $past(conf))
    else $error("configuration read mismatch");
  group_read_a: assert property (reg_rd && reg_addr == REG_GROUP
                                 |=> reg_rdata == {7'h00, $past(row_group_select_bit)})
    else $error("group read mismatch");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared");
  unmapped_rd_a: assert property (reg_rd && reg_addr > REG_GROUP |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Panel drive checks
  row_period_a: assert property (fire && hold_armed |-> hold_cnt == 16'((COL_LAST + 1) * PIX_DIV - 1))
    else $error("row update spacing wrong");
  pixel_off_a: assert property (!row_used |-> !pixel)
    else $error("pixel lit on unused row");
  row_unused_a: assert property (!graphic && !two_line && line |-> !row_used)
    else $error("second line rows used in one-line mode");
  cursor_pix_a: assert property (!graphic && row_used && cur_hit && conf[CONF_CURSOR] && crow == CURSOR_ROW
                                 |-> pixel)
    else $error("cursor underline missing");
  blink_step_a: assert property (scan.frame_end && frame_cnt == 5'(BLINK - 1)
                                 |=> blink_phase != $past(blink_phase))
    else $error("blink phase did not toggle");
endmodule
`default_nettype wire

// file: verification/ocg_host.sv
// Host model: drives the register port of the addressing block
`timescale 1ns/1ps
`default_nettype none
module ocg_host
  import ocg_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Register port
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial
  begin
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write; released lines show the inverse, not stale data
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // One-cycle read; data taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    q = reg_rdata;
  endtask

  // Position or column command, top bit set
  task automatic set_pos(input logic [6:0] p);
    wr(REG_CMD, {1'b1, p});
  endtask

  // Row group command, fixed prefix plus select bit
  task automatic set_group(input logic g);
    wr(REG_CMD, {GY_PREFIX, g});
  endtask
endmodule
`default_nettype wire

// file: verification/ocg_addressing_tb.sv
// Self-checking bench for the display addressing block
`timescale 1ns/1ps
`default_nettype none
module ocg_addressing_tb
  import ocg_pkg::*;
;
  logic         sys_clk;
  logic         rst_n;
  logic [3:0]   reg_addr;
  logic [7:0]   reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [7:0]   reg_rdata;
  logic [15:0]  row_drive;
  logic [99:0]  col_drive;
  logic [7:0]   q;
  logic [15:0]  acc;
  logic [6:0]   pos_list [3] = '{7'h00, 7'h0e, 7'h7f};
  int           n_fail = 0;
  int           comparisons = 0;

  // Clock
  always #20 sys_clk = ~sys_clk;

  ocg_addressing #(.PIX_DIV(1), .BLINK(2)) i_dut (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .row_drive (row_drive),
    .col_drive (col_drive)
  );

  ocg_host i_host (
    .sys_clk   (sys_clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Register read with expected value
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    i_host.rd(a, q);
    check(name, {8'h00, q}, {8'h00, exp});
  endtask

  // Wait for a fresh appearance of one selected row
  task automatic wait_row(input logic [15:0] t);
    int i;
    i = 0;
    while (row_drive === t && i < 4000)
    begin
      @(negedge sys_clk);
      i++;
    end
    while (row_drive !== t && i < 4000)
    begin
      @(negedge sys_clk);
      i++;
    end
  endtask

  // Let rows latched under the old setting drain, then collect a full frame
  task automatic scan_or(output logic [15:0] s);
    s = 16'h0000;
    repeat (210) @(negedge sys_clk);
    repeat (1700)
    begin
      @(negedge sys_clk);
      s = s | row_drive;
    end
  endtask

  // Verdict and end of run
  task automatic results();
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    results();
  end

  // Test sequence
  initial
  begin
    sys_clk = 1'b0;
    rst_n   = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk("conf", REG_CONF, CONF_RST);
    rd_chk("stat", REG_STAT, 8'h00);
    rd_chk("group", REG_GROUP, 8'h00);
    rd_chk("unmapped", 4'hf, 8'h00);
    for (int f = 0; f < 4; f++)
    begin
      i_host.wr(REG_CONF, CONF_RST | 8'(f << CONF_FONT));
      rd_chk("font", REG_CONF, CONF_RST | 8'(f << CONF_FONT));
    end
    i_host.wr(REG_CONF, CONF_RST);
    foreach (pos_list[k])
    begin
      i_host.set_pos(pos_list[k]);
      rd_chk("counter", REG_STAT, {1'b0, pos_list[k]});
      i_host.wr(REG_DATA, 8'h41);
      rd_chk("step", REG_STAT, {1'b0, pos_list[k] + 7'h01});
    end
    // Decrement from zero wraps to the top
    i_host.wr(REG_CONF, 8'h00);
    i_host.set_pos(7'h00);
    i_host.wr(REG_DATA, 8'h41);
    rd_chk("down", REG_STAT, 8'h7f);
    // Two-line addressing and row use
    i_host.wr(REG_CONF, 8'h41);
    i_host.set_pos(7'h40);
    rd_chk("line2", REG_STAT, 8'h40);
    scan_or(acc);
    check("rows2", acc, 16'hffff);
    i_host.wr(REG_CONF, CONF_RST);
    scan_or(acc);
    check("rows1", acc, 16'h00ff);
    i_host.wr(REG_CMD, 8'h45);
    rd_chk("pattern", REG_STAT, 8'h85);
    // User pattern for code 00 shown in cell 1, bit 4 leftmost
    i_host.wr(REG_CMD, 8'h40);
    repeat (8) i_host.wr(REG_DATA, 8'h13);
    rd_chk("patstep", REG_STAT, 8'h88);
    i_host.set_pos(7'h01);
    i_host.wr(REG_DATA, 8'h00);
    wait_row(16'h0080);
    wait_row(16'h0080);
    check("user", {11'h000, col_drive[9:5]}, 16'h0019);
    // Cursor on cell 0x0e, one line
    i_host.wr(REG_CONF, 8'h50);
    i_host.set_pos(7'h0e);
    wait_row(16'h0080);
    wait_row(16'h0080);
    check("cursor1", {11'h000, col_drive[74:70]}, 16'h001f);
    // Cursor on cell 0x46, two lines
    i_host.wr(REG_CONF, 8'h51);
    i_host.set_pos(7'h46);
    wait_row(16'h8000);
    wait_row(16'h8000);
    check("cursor2", {11'h000, col_drive[34:30]}, 16'h001f);
    // Graphic mode: group select and column range
    i_host.wr(REG_CONF, 8'h42);
    i_host.set_group(1'b1);
    rd_chk("grp1", REG_GROUP, 8'h01);
    i_host.wr(REG_CMD, 8'h42);
    rd_chk("grpkeep", REG_GROUP, 8'h01);
    i_host.set_pos(7'h63);
    rd_chk("col100", REG_STAT, 8'h63);
    i_host.wr(REG_DATA, 8'h80);
    rd_chk("colwrap", REG_STAT, 8'h00);
    i_host.set_group(1'b0);
    rd_chk("grp0", REG_GROUP, 8'h00);
    i_host.set_pos(7'h00);
    i_host.wr(REG_DATA, 8'h01);
    i_host.wr(REG_CONF, 8'h02);
    i_host.set_pos(7'h01);
    i_host.wr(REG_DATA, 8'hfe);
    rd_chk("gdown", REG_STAT, 8'h00);
    // Writes elsewhere while the panel refreshes
    i_host.set_pos(7'h32);
    repeat (3) i_host.wr(REG_DATA, 8'hff);
    wait_row(16'h0001);
    wait_row(16'h0001);
    check("pix0", {14'h0000, col_drive[1:0]}, 16'h0001);
    wait_row(16'h0002);
    check("pix1", {14'h0000, col_drive[1:0]}, 16'h0002);
    wait_row(16'h4000);
    check("pix14", {15'h0000, col_drive[99]}, 16'h0000);
    wait_row(16'h8000);
    check("pix15", {15'h0000, col_drive[99]}, 16'h0001);
    results();
  end
endmodule
`default_nettype wire
